// *** sdwt_pkg.sv ***
// Overview of operation
// - Mode 00 eight beats; mode 01 bit high eight
// - Mode 01 with bit low: four-beat chop
// - Mode 10 always fixed four-beat chop
// - Device takes data write latency after command
// - Precharge waits latency plus 4/2 plus recovery
// - Explicit precharge also waits activate-to-precharge time
// - Other-group read waits short turnaround time
// - Same-group read waits long turnaround time
// - Recovery counts from edge after last data, two clocks later in mode 01 chop
// - Auto precharge starts after write recovery
// - Inversion enabled uses inversion recovery time
// - Two-clock preamble forbids lowest write latency
package sdwt_pkg;
	// ==========================================
	// Modes and commands
	typedef enum logic [1:0] {
		SDWT_BM_EIGHT = 2'h0,
		SDWT_BM_OTF   = 2'h1,
		SDWT_BM_FIXED = 2'h2
	} sdwt_bmode_t;

	typedef enum logic [2:0] {
		SDWT_NOP = 3'h0,
		SDWT_ACT = 3'h1,
		SDWT_WR  = 3'h2,
		SDWT_RD  = 3'h3,
		SDWT_PRE = 3'h4
	} sdwt_cmd_t;

	localparam int          SDWT_CW        = 8;
	localparam int          SDWT_BKW       = 4;
	localparam logic [7:0]  SDWT_CLK_LONG  = 8'h04;
	localparam logic [7:0]  SDWT_CLK_SHORT = 8'h02;
	localparam logic [7:0]  SDWT_CWL_LOW   = 8'h09;
	localparam int          SDWT_DLY       = 64;

	// ==========================================
	// Register map
	localparam logic [7:0]  SDWT_A_CTRL  = 8'h00;
	localparam logic [7:0]  SDWT_A_TIM0  = 8'h04;
	localparam logic [7:0]  SDWT_A_TIM1  = 8'h08;
	localparam logic [7:0]  SDWT_A_CMD   = 8'h0c;
	localparam logic [7:0]  SDWT_A_WDATA = 8'h10;
	localparam logic [7:0]  SDWT_A_STAT  = 8'h14;
	localparam int          SDWT_F_BM    = 0;
	localparam int          SDWT_F_DBI   = 2;
	localparam int          SDWT_F_PRE2  = 3;
	localparam int          SDWT_F_LOAD  = 4;
	localparam int          SDWT_F_AL    = 0;
	localparam int          SDWT_F_CWL   = 8;
	localparam int          SDWT_F_TWR   = 16;
	localparam int          SDWT_F_TWRD  = 24;
	localparam int          SDWT_F_WTRS  = 0;
	localparam int          SDWT_F_WTRL  = 8;
	localparam int          SDWT_F_ACTIVATE_TO_PRECHARGE_TIME  = 16;
	localparam int          SDWT_F_KIND  = 0;
	localparam int          SDWT_F_BANK  = 4;
	localparam int          SDWT_F_A12   = 8;
	localparam int          SDWT_F_AP    = 9;
	localparam logic [31:0] SDWT_R_TIM0  = 32'h0c0c0900;
	localparam logic [31:0] SDWT_R_TIM1  = 32'h001c0602;

	// Chop is decided per command only in mode 01
	function automatic logic sdwt_is_chop(input logic [1:0] m, input logic a12);
		sdwt_is_chop = (m == SDWT_BM_FIXED) || ((m == SDWT_BM_OTF) && !a12);
	endfunction : sdwt_is_chop

	// Clocks from write latency to the recovery reference edge
	function automatic logic [7:0] sdwt_span(input logic [1:0] m);
		sdwt_span = (m == SDWT_BM_FIXED) ? SDWT_CLK_SHORT : SDWT_CLK_LONG;
	endfunction : sdwt_span

	function automatic logic [7:0] sdwt_max(input logic [7:0] a, input logic [7:0] b);
		sdwt_max = (a > b) ? a : b;
	endfunction : sdwt_max
endpackage : sdwt_pkg

// *** sdwt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sdwt_if;
	import sdwt_pkg::*;
	logic              cmd_valid;
	sdwt_cmd_t         cmd_kind;
	logic [SDWT_BKW-1:0] cmd_bank;
	logic              cmd_a12;
	logic              cmd_ap;
	logic [31:0]       wdata;
	logic              mode_load;
	logic [1:0]        mode_burst;
	logic [7:0]        mode_wl;
	logic [7:0]        mode_twr;
	logic              data_accept;

	modport ctl (output cmd_valid, cmd_kind, cmd_bank, cmd_a12, cmd_ap, wdata,
		mode_load, mode_burst, mode_wl, mode_twr, input data_accept);
	modport dev (input cmd_valid, cmd_kind, cmd_bank, cmd_a12, cmd_ap, wdata,
		mode_load, mode_burst, mode_wl, mode_twr, output data_accept);
endinterface : sdwt_if
`default_nettype wire

// *** sdwt_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdwt_dev #(
	parameter int BANKS = 16
) (
	input  wire logic                    CLOCK,
	input  wire logic                    RST_B,
	input  wire logic                    CE,
	sdwt_if.dev                          LINK,
	output logic [31:0]                  DATA_OUT,
	output logic                         DATA_STROBE,
	output logic                         PRECHARGE_START,
	output logic [sdwt_pkg::SDWT_BKW-1:0] PRECHARGE_BANK
);
	import sdwt_pkg::*;

	// ==========================================
	// Mode register zero copy
	logic [1:0] burst_reg;
	logic [7:0] wl_reg;
	logic [7:0] twr_reg;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			burst_reg <= 2'h0;
			wl_reg    <= 8'h09;
			twr_reg   <= 8'h0c;
		end else if (CE && LINK.mode_load) begin
			burst_reg <= LINK.mode_burst;
			wl_reg    <= LINK.mode_wl;
			twr_reg   <= LINK.mode_twr;
		end
	end

	// ==========================================
	// Write latency delay line, one slot per clock
	logic [SDWT_DLY-1:0] go_reg;
	logic [SDWT_DLY-1:0] chop_reg;
	logic [SDWT_DLY-1:0] ap_reg;
	logic [SDWT_BKW-1:0] bank_line [SDWT_DLY];
	logic                wr_now;
	assign wr_now = LINK.cmd_valid && (LINK.cmd_kind == SDWT_WR);
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			go_reg   <= '0;
			chop_reg <= '0;
			ap_reg   <= '0;
		end else if (CE) begin
			go_reg   <= {go_reg[SDWT_DLY-2:0], wr_now};
			chop_reg <= {chop_reg[SDWT_DLY-2:0], sdwt_is_chop(burst_reg, LINK.cmd_a12)};
			ap_reg   <= {ap_reg[SDWT_DLY-2:0], LINK.cmd_ap};
		end
	end
	always_ff @(posedge CLOCK) begin
		if (CE) begin
			bank_line[0] <= LINK.cmd_bank;
			for (int i = 1; i < SDWT_DLY; i++) begin
				bank_line[i] <= bank_line[i-1];
			end
		end
	end

	// ==========================================
	// Data window; tap at wl-2 so the window opens wl clocks after the command
	logic [5:0] tap;
	assign tap = wl_reg[5:0] - 6'h2;
	logic [7:0]          left_reg;
	logic [7:0]          take_reg;
	logic                wap_reg;
	logic [SDWT_BKW-1:0] wbank_reg;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			left_reg  <= 8'h0;
			take_reg  <= 8'h0;
			wap_reg   <= 1'b0;
			wbank_reg <= '0;
		end else if (CE) begin
			if (go_reg[tap]) begin
				left_reg  <= sdwt_span(burst_reg);
				take_reg  <= chop_reg[tap] ? SDWT_CLK_SHORT : SDWT_CLK_LONG;
				wap_reg   <= ap_reg[tap];
				wbank_reg <= bank_line[tap];
			end else if (left_reg != 8'h0) begin
				left_reg <= left_reg - 8'h1;
				take_reg <= (take_reg != 8'h0) ? take_reg - 8'h1 : 8'h0;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			LINK.data_accept <= 1'b0;
			DATA_OUT         <= 32'h0;
			DATA_STROBE      <= 1'b0;
		end else if (CE) begin
			LINK.data_accept <= go_reg[tap] || (take_reg > 8'h1);
			DATA_STROBE      <= LINK.data_accept;
			if (LINK.data_accept) begin
				DATA_OUT <= LINK.wdata;
			end
		end
	end

	// ==========================================
	// Auto precharge waits recovery from the edge after the last data clock, two clocks later in mode 01 chop
	logic [7:0] apc_reg [BANKS];
	logic       last_clk;
	assign last_clk = (left_reg == 8'h1) && !go_reg[tap];
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			for (int b = 0; b < BANKS; b++) begin
				apc_reg[b] <= 8'h0;
			end
			PRECHARGE_START <= 1'b0;
			PRECHARGE_BANK  <= '0;
		end else if (CE) begin
			PRECHARGE_START <= 1'b0;
			for (int b = 0; b < BANKS; b++) begin
				if (last_clk && wap_reg && (wbank_reg == SDWT_BKW'(b))) begin
					// Loaded on the last clock of the span, so one more clock reaches the reference edge
					apc_reg[b] <= twr_reg + 8'h1;
				end else if (apc_reg[b] != 8'h0) begin
					apc_reg[b] <= apc_reg[b] - 8'h1;
					if (apc_reg[b] == 8'h1) begin
						PRECHARGE_START <= 1'b1;
						PRECHARGE_BANK  <= SDWT_BKW'(b);
					end
				end
			end
		end
	end
endmodule : sdwt_dev
`default_nettype wire

// *** sdwt_ctl.sv ***
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdwt_ctl #(
	parameter int BANKS  = 16,
	parameter int GROUPS = 4
) (
	input  wire logic        CLOCK,
	input  wire logic        RST_B,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	sdwt_if.ctl              LINK
);
	import sdwt_pkg::*;

	// ==========================================
	// APB registers
	logic [31:0] ctrl_reg;
	logic [31:0] tim0_reg;
	logic [31:0] tim1_reg;
	logic [31:0] cmd_reg;
	logic [31:0] wdata_reg;
	logic        pend_reg;
	logic        issue;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	assign wr_acc = PSEL && PENABLE && PWRITE && PREADY;
	assign rd_acc = PSEL && !PENABLE && !PWRITE;
	assign mapped = (PADDR <= SDWT_A_STAT) && (PADDR[1:0] == 2'h0);

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg  <= 32'h0;
			tim0_reg  <= SDWT_R_TIM0;
			tim1_reg  <= SDWT_R_TIM1;
			cmd_reg   <= 32'h0;
			wdata_reg <= 32'h0;
		end else if (CE && wr_acc) begin
			case (PADDR)
				SDWT_A_CTRL:  ctrl_reg  <= PWDATA;
				SDWT_A_TIM0:  tim0_reg  <= PWDATA;
				SDWT_A_TIM1:  tim1_reg  <= PWDATA;
				SDWT_A_CMD:   cmd_reg   <= pend_reg ? cmd_reg : PWDATA;
				SDWT_A_WDATA: wdata_reg <= PWDATA;
				default:      ;
			endcase
		end
	end

	// A new command is dropped while one is still pending
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pend_reg <= 1'b0;
		end else if (CE) begin
			if (wr_acc && (PADDR == SDWT_A_CMD) && !pend_reg) begin
				pend_reg <= 1'b1;
			end else if (issue) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Decoded settings
	logic [1:0]           bmode;
	logic [7:0]           wl;
	logic [7:0]           cas_write_latency;
	logic [7:0]           write_recovery_time;
	sdwt_cmd_t            kind;
	logic [SDWT_BKW-1:0]  bank;
	logic [1:0]           grp;
	assign bmode = ctrl_reg[SDWT_F_BM +: 2];
	// Lowest setting is not usable with a two-clock preamble, so it is bumped
	assign cas_write_latency   = (ctrl_reg[SDWT_F_PRE2] && (tim0_reg[SDWT_F_CWL +: 8] <= SDWT_CWL_LOW))
		? SDWT_CWL_LOW + 8'h1 : tim0_reg[SDWT_F_CWL +: 8];
	assign wl    = tim0_reg[SDWT_F_AL +: 8] + cas_write_latency;
	assign write_recovery_time   = ctrl_reg[SDWT_F_DBI] ? tim0_reg[SDWT_F_TWRD +: 8] : tim0_reg[SDWT_F_TWR +: 8];
	assign kind  = sdwt_cmd_t'(cmd_reg[SDWT_F_KIND +: 3]);
	assign bank  = cmd_reg[SDWT_F_BANK +: SDWT_BKW];
	assign grp   = bank[SDWT_BKW-1 -: 2];

	// ==========================================
	// Spacing counters, loaded relative to the command edge
	logic [7:0] rec_reg  [BANKS];
	logic [7:0] ras_reg  [BANKS];
	logic [7:0] wtrl_reg [GROUPS];
	logic [7:0] wtrs_reg;
	logic [7:0] ref_clk;
	logic       legal;
	assign ref_clk = wl + sdwt_span(bmode);

	always_comb begin
		case (kind)
			SDWT_RD:  legal = (wtrs_reg == 8'h0) && (wtrl_reg[grp] == 8'h0);
			SDWT_PRE: legal = (rec_reg[bank] == 8'h0) && (ras_reg[bank] == 8'h0);
			default:  legal = 1'b1;
		endcase
	end
	assign issue = pend_reg && legal;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			for (int b = 0; b < BANKS; b++) begin
				rec_reg[b] <= 8'h0;
				ras_reg[b] <= 8'h0;
			end
		end else if (CE) begin
			for (int b = 0; b < BANKS; b++) begin
				if (issue && (bank == SDWT_BKW'(b)) && (kind == SDWT_WR)) begin
					rec_reg[b] <= sdwt_max(rec_reg[b], ref_clk + write_recovery_time);
				end else if (rec_reg[b] != 8'h0) begin
					rec_reg[b] <= rec_reg[b] - 8'h1;
				end
				if (issue && (bank == SDWT_BKW'(b)) && (kind == SDWT_ACT)) begin
					ras_reg[b] <= tim1_reg[SDWT_F_ACTIVATE_TO_PRECHARGE_TIME +: 8];
				end else if (ras_reg[b] != 8'h0) begin
					ras_reg[b] <= ras_reg[b] - 8'h1;
				end
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			for (int g = 0; g < GROUPS; g++) begin
				wtrl_reg[g] <= 8'h0;
			end
			wtrs_reg <= 8'h0;
		end else if (CE) begin
			for (int g = 0; g < GROUPS; g++) begin
				if (issue && (kind == SDWT_WR) && (grp == 2'(g))) begin
					wtrl_reg[g] <= sdwt_max(wtrl_reg[g], ref_clk + tim1_reg[SDWT_F_WTRL +: 8]);
				end else if (wtrl_reg[g] != 8'h0) begin
					wtrl_reg[g] <= wtrl_reg[g] - 8'h1;
				end
			end
			if (issue && (kind == SDWT_WR)) begin
				wtrs_reg <= sdwt_max(wtrs_reg, ref_clk + tim1_reg[SDWT_F_WTRS +: 8]);
			end else if (wtrs_reg != 8'h0) begin
				wtrs_reg <= wtrs_reg - 8'h1;
			end
		end
	end

	// ==========================================
	// Command and mode outputs
	// Load pulse trails the control write by one clock so the mode fields already show the new value
	logic load_reg;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			load_reg <= 1'b0;
		end else if (CE) begin
			load_reg <= wr_acc && (PADDR == SDWT_A_CTRL) && PWDATA[SDWT_F_LOAD];
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			LINK.cmd_valid  <= 1'b0;
			LINK.cmd_kind   <= SDWT_NOP;
			LINK.cmd_bank   <= '0;
			LINK.cmd_a12    <= 1'b0;
			LINK.cmd_ap     <= 1'b0;
			LINK.mode_load  <= 1'b0;
			LINK.mode_burst <= 2'h0;
			LINK.mode_wl    <= 8'h09;
			LINK.mode_twr   <= 8'h0c;
		end else if (CE) begin
			LINK.cmd_valid  <= issue;
			LINK.cmd_kind   <= issue ? kind : SDWT_NOP;
			LINK.cmd_bank   <= bank;
			LINK.cmd_a12    <= cmd_reg[SDWT_F_A12];
			LINK.cmd_ap     <= issue && (kind == SDWT_WR) && cmd_reg[SDWT_F_AP];
			LINK.mode_load  <= load_reg;
			LINK.mode_burst <= bmode;
			LINK.mode_wl    <= wl;
			LINK.mode_twr   <= write_recovery_time;
		end
	end

	// Write data is wdata_reg registered every clock, whether or not the device's accept window is open
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			LINK.wdata <= 32'h0;
		end else if (CE) begin
			LINK.wdata <= wdata_reg;
		end
	end

	// ==========================================
	// APB answer: zero wait states, error on unmapped words
	logic [31:0] stat;
	assign stat = {16'h0, 6'h0, (wtrs_reg != 8'h0), LINK.data_accept, 7'h0, pend_reg};
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA  <= 32'h0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			if (rd_acc) begin
				case (PADDR)
					SDWT_A_CTRL:  PRDATA <= ctrl_reg;
					SDWT_A_TIM0:  PRDATA <= tim0_reg;
					SDWT_A_TIM1:  PRDATA <= tim1_reg;
					SDWT_A_CMD:   PRDATA <= cmd_reg;
					SDWT_A_WDATA: PRDATA <= wdata_reg;
					SDWT_A_STAT:  PRDATA <= stat;
					default:      PRDATA <= 32'h0;
				endcase
			end
		end
	end
endmodule : sdwt_ctl
`default_nettype wire

// *** sdwt_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdwt_monitor (
	input wire logic                          CLOCK,
	input wire logic                          RST_B,
	input wire logic                          cmd_valid,
	input wire sdwt_pkg::sdwt_cmd_t           cmd_kind,
	input wire logic [sdwt_pkg::SDWT_BKW-1:0] cmd_bank,
	input wire logic                          cmd_a12,
	input wire logic                          mode_load,
	input wire logic [1:0]                    mode_burst,
	input wire logic [7:0]                    mode_wl,
	input wire logic [7:0]                    mode_twr,
	input wire logic                          data_accept
);
	import sdwt_pkg::*;
	// ==========================================
	// Write tracking
	logic [7:0] since_reg, wl_reg, ref_reg, base_reg, mwl_reg, mtwr_reg;
	logic [1:0] mbm_reg;
	logic [3:0] bank_reg;
	logic       chop_reg;
	logic       trk;
	assign trk = since_reg != 8'h00;
	// Device view of the mode, copied only on the load pulse
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			mbm_reg  <= 2'h0;
			mwl_reg  <= 8'h09;
			mtwr_reg <= 8'h0c;
		end else if (mode_load) begin
			mbm_reg  <= mode_burst;
			mwl_reg  <= mode_wl;
			mtwr_reg <= mode_twr;
		end
	end
	// One write tracked at a time, so overlapping bursts are not judged here
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			since_reg <= 8'h00;
			wl_reg    <= 8'h00;
			ref_reg   <= 8'h00;
			base_reg  <= 8'h00;
			bank_reg  <= 4'h0;
			chop_reg  <= 1'b0;
		end else if (cmd_valid && cmd_kind == SDWT_WR) begin
			since_reg <= 8'h01;
			wl_reg    <= mwl_reg;
			ref_reg   <= mwl_reg + ((mbm_reg == 2'h2) ? 8'h02 : 8'h04);
			base_reg  <= mwl_reg + ((mbm_reg == 2'h2) ? 8'h02 : 8'h04) + mtwr_reg;
			bank_reg  <= cmd_bank;
			chop_reg  <= (mbm_reg == 2'h2) || (mbm_reg == 2'h1 && !cmd_a12);
		end else if (trk && since_reg != 8'hff) begin
			since_reg <= since_reg + 8'h01;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	a_accept_open: assert property (trk && since_reg == wl_reg |-> data_accept)
		else $error("data window did not open at write latency");
	a_accept_quiet: assert property (trk && since_reg < wl_reg |-> !data_accept)
		else $error("data taken before write latency");
	a_accept_aligned: assert property ($rose(data_accept) |-> trk && since_reg == wl_reg)
		else $error("data window opened at a wrong time");
	a_eight_len: assert property (trk && !chop_reg && since_reg == wl_reg + 8'h03 |-> data_accept ##1 !data_accept)
		else $error("eight-beat burst length wrong");
	a_chop_len: assert property (trk && chop_reg && since_reg == wl_reg + 8'h01 |-> data_accept ##1 !data_accept)
		else $error("chopped burst length wrong");
	a_pre_recovery: assert property (cmd_valid && cmd_kind == SDWT_PRE && trk && cmd_bank == bank_reg |-> since_reg >= base_reg)
		else $error("precharge issued before write recovery");
	a_rd_turnaround: assert property (cmd_valid && cmd_kind == SDWT_RD && trk |-> since_reg > ref_reg)
		else $error("read issued before turnaround");
	a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
		else $error("command strobe held two cycles");
	cover property (trk && chop_reg && since_reg == wl_reg);
	cover property (cmd_valid && cmd_kind == SDWT_PRE && trk);
	cover property (cmd_valid && cmd_kind == SDWT_RD && trk);
endmodule : sdwt_monitor
`default_nettype wire

// *** sdwt_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdwt_test;
	import sdwt_pkg::*;
	// ==========================================
	// Harness
	logic        CLOCK = 1'b0, RST_B = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, DATA_OUT, rd, wd;
	logic        PREADY, PSLVERR, DATA_STROBE, PRECHARGE_START, er;
	logic [3:0]  PRECHARGE_BANK, apb_bank;
	int          errors = 0, num_checks = 0, cyc = 0, t_act, t_wr, t_rd, t_pre, t_ap, t_acc, n_acc;
	sdwt_if link();
	sdwt_ctl i_sdwt_ctl (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK(link.ctl));
	sdwt_dev i_sdwt_dev (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .LINK(link.dev), .DATA_OUT(DATA_OUT),
		.DATA_STROBE(DATA_STROBE), .PRECHARGE_START(PRECHARGE_START), .PRECHARGE_BANK(PRECHARGE_BANK));
	sdwt_monitor i_monitor (.CLOCK(CLOCK), .RST_B(RST_B), .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind),
		.cmd_bank(link.cmd_bank), .cmd_a12(link.cmd_a12), .mode_load(link.mode_load), .mode_burst(link.mode_burst),
		.mode_wl(link.mode_wl), .mode_twr(link.mode_twr), .data_accept(link.data_accept));
	always #5 CLOCK = ~CLOCK;
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// One cycle of slack: the rules give only the earliest edge
	task automatic near(input string nm, input int exp, input int got);
		num_checks++;
		if (got < exp || got > exp + 1) begin
			errors++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : near
	task automatic print_verdict;
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20) begin
			check("apb_timeout", 32'h0, 32'h1);
			print_verdict();
		end
	endtask : apb
	task automatic cmd(input logic [2:0] k, input logic [3:0] b, input logic a12, input logic ap);
		int n;
		apb(SDWT_A_CMD, 1'b1, {22'h0, ap, a12, b, 1'b0, k});
		n = 0;
		do begin
			apb(SDWT_A_STAT, 1'b0, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			check("cmd_timeout", 32'h0, 32'h1);
			print_verdict();
		end
	endtask : cmd
	// ==========================================
	// Event log on the link
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (link.cmd_valid === 1'b1) begin
			case (link.cmd_kind)
				SDWT_ACT: t_act <= cyc;
				SDWT_RD:  t_rd <= cyc;
				SDWT_PRE: t_pre <= cyc;
				SDWT_WR: begin
					t_wr <= cyc;
					n_acc <= 0;
				end
				default: ;
			endcase
		end
		if (link.data_accept === 1'b1) begin
			if (n_acc == 0)
				t_acc <= cyc;
			n_acc <= n_acc + 1;
		end
		if (PRECHARGE_START === 1'b1) begin
			t_ap <= cyc;
			apb_bank <= PRECHARGE_BANK;
		end
		if (DATA_STROBE === 1'b1)
			check("data_out", wd, DATA_OUT);
	end
	// ==========================================
	// Sequence
	initial begin
		int it, bm, sg, data_bus_inversion, p2, ap, al, cas_write_latency, write_recovery_time, twd, ws, wlg, activate_to_precharge_time, wl, sp, ln, rec, n;
		logic       a12;
		logic [3:0] b, rb;
		it = $urandom(32'h4fc0);
		repeat (6) @(posedge CLOCK);
		RST_B <= 1'b1;
		apb(SDWT_A_TIM0, 1'b0, 32'h0);
		check("tim0_reset", SDWT_R_TIM0, rd);
		apb(SDWT_A_TIM1, 1'b0, 32'h0);
		check("tim1_reset", SDWT_R_TIM1, rd);
		apb(8'h18, 1'b0, 32'h0);
		check("unmapped", 32'h1, {31'h0, er});
		check("unmapped_data", 32'h0, rd);
		for (it = 0; it < 12; it++) begin
			bm = it % 3;
			a12 = $urandom;
			sg = $urandom % 2;
			data_bus_inversion = $urandom % 2;
			p2 = $urandom % 2;
			ap = (it % 4 == 3);
			al = $urandom % 4;
			cas_write_latency = (it < 4) ? 9 : 9 + $urandom % 4;
			write_recovery_time = 12 + $urandom % 4;
			twd = write_recovery_time + 1 + $urandom % 3;
			ws = 1 + $urandom % 3;
			wlg = 4 + $urandom % 4;
			activate_to_precharge_time = (it % 2) ? 60 : 4;
			b = $urandom;
			rb = sg ? {b[3:2], ~b[1:0]} : {~b[3:2], b[1:0]};
			wl = al + ((p2 && cas_write_latency == 9) ? 10 : cas_write_latency);
			sp = (bm == 2) ? 2 : 4;
			ln = (bm == 2 || (bm == 1 && !a12)) ? 2 : 4;
			rec = wl + sp + (data_bus_inversion ? twd : write_recovery_time);
			wd = $urandom;
			apb(SDWT_A_TIM0, 1'b1, {twd[7:0], write_recovery_time[7:0], cas_write_latency[7:0], al[7:0]});
			apb(SDWT_A_TIM1, 1'b1, {8'h0, activate_to_precharge_time[7:0], wlg[7:0], ws[7:0]});
			apb(SDWT_A_WDATA, 1'b1, wd);
			apb(SDWT_A_CTRL, 1'b1, {27'h0, 1'b1, p2[0], data_bus_inversion[0], bm[1:0]});
			cmd(SDWT_ACT, b, 1'b0, 1'b0);
			cmd(SDWT_WR, b, a12, ap[0]);
			cmd(SDWT_RD, rb, a12, 1'b0);
			check("wr_to_data", wl, t_acc - t_wr);
			check("beats", ln, n_acc);
			near("rd_turn", t_wr + wl + sp + (sg ? wlg : ws), t_rd);
			if (ap) begin
				n = 0;
				while (t_ap <= t_wr && n < 200) begin
					@(posedge CLOCK);
					n++;
				end
				near("ap_start", t_wr + rec, t_ap);
				check("ap_bank", b, apb_bank);
			end else begin
				cmd(SDWT_PRE, b, 1'b0, 1'b0);
				near("pre_gap", (t_wr + rec > t_act + activate_to_precharge_time) ? t_wr + rec : t_act + activate_to_precharge_time, t_pre);
			end
		end
		print_verdict();
	end
endmodule : sdwt_test
`default_nettype wire
